/* File: design/esf_pkg.sv */
// Purpose: shared constants and carriers for the status frame emitter
// Assumes: byte-wide serial host link, api mode 1 (no escaping)
// Notes:   frame fields are serialised most significant byte first
package esf_pkg;

    // ************************************************
    // frame layout
    // ************************************************
    localparam logic [7:0] START_DELIM   = 8'h7E;
    localparam logic [7:0] TYPE_EXT_STAT = 8'h98;
    localparam logic [7:0] TYPE_RMT_RSP  = 8'h97;
    localparam logic [7:0] CSUM_BASE     = 8'hFF;
    localparam logic [7:0] API_PLAIN     = 8'h01;

    // ************************************************
    // status codes
    // ************************************************
    localparam logic [7:0] SC_SESS_UP    = 8'h3B;
    localparam logic [7:0] SC_SESS_END   = 8'h3C;
    localparam logic [7:0] SC_AUTH_FAIL  = 8'h3D;

    localparam logic [7:0] END_PEER      = 8'h00;
    localparam logic [7:0] END_TIMEOUT   = 8'h01;
    localparam logic [7:0] END_BAD_CTR   = 8'h02;
    localparam logic [7:0] END_CTR_OVF   = 8'h03;
    localparam logic [7:0] END_NO_MEM    = 8'h04;

    localparam logic [7:0] CMD_OK        = 8'h00;
    localparam logic [7:0] CMD_ERROR     = 8'h01;
    localparam logic [7:0] CMD_BAD_CMD   = 8'h02;
    localparam logic [7:0] CMD_BAD_PARAM = 8'h03;
    localparam logic [7:0] CMD_TX_FAIL   = 8'h04;

    // ************************************************
    // sizes
    // ************************************************
    localparam int MAX_BODY     = 32;
    localparam int FIFO_DEPTH   = 16;
    localparam int BYTE_W       = 8;
    localparam logic [7:0] LEN_SESS_UP  = 8'h0D;
    localparam logic [7:0] LEN_SESS_ETC = 8'h0B;
    localparam logic [7:0] LEN_RSP_BASE = 8'h0F;

    typedef enum logic [1:0] {EV_SESS_UP, EV_SESS_END, EV_AUTH_FAIL, EV_VJOIN} esf_ev_kind_t;

    typedef struct packed {
        esf_ev_kind_t kind;
        logic [63:0]  addr;
        logic [7:0]   code;
        logic [7:0]   opts;
        logic [15:0]  timeout;
    } esf_event_t;

    typedef struct packed {
        logic [7:0]   frame_id;
        logic [63:0]  src64;
        logic [15:0]  src16;
        logic [15:0]  at_cmd;
        logic [7:0]   status;
        logic         param_set;
        logic [3:0]   data_len;
        logic [63:0]  data;
    } esf_rsp_t;

    typedef struct packed {
        logic         sop;
        logic         eop;
        logic [7:0]   data;
    } esf_byte_t;

endpackage

/* File: design/esf_fifo.sv */
// Purpose: synchronous fifo between framer and host link
// Assumes: single clock, registered read data
// Notes:   full and empty are exact; no write when full
`timescale 1ns/100ps
module esf_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             wr, rd;

    // ************************************************
    // next state
    // ************************************************
    always_comb
    begin
        wr    = in_valid && (cnt_q != (AW+1)'(DEPTH));
        rd    = (cnt_q != '0) && (!ov_q || out_ready);
        wp_d  = wr ? wp_q + 1'b1 : wp_q;
        rp_d  = rd ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
        ov_d  = rd ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d  = rd ? mem_q[rp_q] : od_q;
    end

    always_ff @(posedge clk)
    begin
        if (wr)
        begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end
        else
        begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = ov_q;
    assign out_data  = od_q;
endmodule

/* File: design/esf_emitter.sv */
// Purpose: builds extended status and remote command response frames
// Assumes: settings are static while a frame is pending
// Notes:   one frame at a time; bytes go through a 16-word fifo
//          refused requests get a ready pulse and emit no bytes
//          fifo depth bounds how far a stalled host may lag
// How it works
// [R1] every frame opens with start delimiter byte
// [R2] two length bytes count frame body
// [R3] extended status frames carry type 0x98
// [R4] status code at offset four, then data
// [R5] checksum is 0xFF minus body sum
// [R6] verbose join frames need joining controls enabled
// [R7] session events need extended options enabled
// [R8] 0x3B carries address, options, timeout
// [R9] 0x3C carries peer address and reason
// [R10] reason codes 0x00 to 0x04 passed through
// [R11] 0x3D carries client address and error
// [R12] api mode 1 sends bytes unescaped
// [R13] response type 0x97 echoes frame identifier
// [R14] parameter writes omit data, shorter length
// [R15] command status byte 0x00 to 0x04
// [R16] zero frame identifier suppresses the response
// [R17] checksum accumulates; frames never interleave
// [R18] host discards frames with bad checksum
`timescale 1ns/100ps
module esf_emitter
    import esf_pkg::*;
#(
    parameter int FDEPTH = esf_pkg::FIFO_DEPTH
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ev_valid,
    output logic                      ev_ready,
    input  wire esf_pkg::esf_event_t  ev,
    input  wire logic [7:0]           vjoin_len,
    input  wire logic [63:0]          vjoin_data,
    input  wire logic                 rsp_valid,
    output logic                      rsp_ready,
    input  wire esf_pkg::esf_rsp_t    rsp,
    input  wire logic                 joining_controls_setting,
    input  wire logic                 extended_api_options_setting,
    input  wire logic [7:0]           api_mode_setting,
    output logic                      host_valid,
    input  wire logic                 host_ready,
    output esf_pkg::esf_byte_t        host_byte,
    output logic                      busy
);
    import esf_pkg::*;

    typedef enum {S_IDLE, S_HEAD, S_BODY, S_SUM} esf_state_t;

    esf_state_t       st_q, st_d;
    logic [7:0]       body_q [MAX_BODY];
    logic [7:0]       body_d [MAX_BODY];
    logic [7:0]       len_q, len_d;
    logic [7:0]       idx_q, idx_d;
    logic [7:0]       sum_q, sum_d;
    logic             ev_rdy_q, ev_rdy_d;
    logic             rsp_rdy_q, rsp_rdy_d;
    logic             busy_q, busy_d;
    esf_byte_t        push;
    logic             push_v;
    logic             f_ready;
    logic [9:0]       f_out;
    logic             take_ev, take_rsp, ev_drop, rsp_drop;
    logic             ev_ok;

    // ************************************************
    // helpers
    // ************************************************
    // big-endian byte of a 64-bit word
    function automatic logic [7:0] be8(input logic [63:0] w, input int i);
        be8 = w[8*(7-i) +: 8];
    endfunction

    // status and command data never exceed eight bytes
    function automatic logic [7:0] cap8(input logic [7:0] n);
        cap8 = (n > 8'd8) ? 8'd8 : n;
    endfunction

    // one host link byte with its frame marks
    function automatic esf_byte_t mk_byte(input logic s, input logic e, input logic [7:0] d);
        mk_byte = '{sop: s, eop: e, data: d};
    endfunction

    // ************************************************
    // acceptance
    // ************************************************
    always_comb
    begin
        case (ev.kind)
            EV_VJOIN: ev_ok = joining_controls_setting;  // [R6]
            default:  ev_ok = extended_api_options_setting;  // [R7]
        endcase
        // bytes are never escaped; other modes emit nothing
        take_ev  = (st_q == S_IDLE) && ev_valid && ev_ok && api_mode_setting == API_PLAIN;  // [R12]
        ev_drop  = (st_q == S_IDLE) && ev_valid && !take_ev;
        take_rsp = (st_q == S_IDLE) && !ev_valid && rsp_valid && rsp.frame_id != 8'h00
                   && api_mode_setting == API_PLAIN;
        rsp_drop = (st_q == S_IDLE) && !ev_valid && rsp_valid && !take_rsp;  // [R16]
    end

    // ************************************************
    // framer
    // ************************************************
    always_comb
    begin
        st_d      = st_q;
        body_d    = body_q;
        len_d     = len_q;
        idx_d     = idx_q;
        sum_d     = sum_q;
        push_v    = 1'b0;
        push      = mk_byte(1'b0, 1'b0, 8'h00);
        case (st_q)
            S_IDLE:
            begin
                idx_d = 8'h00;
                sum_d = 8'h00;
                if (take_ev)
                begin
                    body_d[0] = TYPE_EXT_STAT;  // [R3]
                    st_d      = S_HEAD;
                    case (ev.kind)
                        EV_SESS_UP:
                        begin
                            body_d[1] = SC_SESS_UP;  // [R8]
                            for (int i = 0; i < 8; i++)
                            begin
                                body_d[2+i] = be8(ev.addr, i);
                            end
                            body_d[10] = ev.opts;
                            body_d[11] = ev.timeout[15:8];
                            body_d[12] = ev.timeout[7:0];
                            len_d      = LEN_SESS_UP;
                        end
                        EV_SESS_END, EV_AUTH_FAIL:
                        begin
                            body_d[1] = (ev.kind == EV_SESS_END) ? SC_SESS_END : SC_AUTH_FAIL;  // [R9] [R11]
                            for (int i = 0; i < 8; i++)
                            begin
                                body_d[2+i] = be8(ev.addr, i);
                            end
                            body_d[10] = ev.code;  // [R10]
                            len_d      = LEN_SESS_ETC;
                        end
                        default:
                        begin
                            body_d[1] = ev.code;  // [R4]
                            for (int i = 0; i < 8; i++)
                            begin
                                body_d[2+i] = be8(vjoin_data, i);
                            end
                            // status data limited to eight bytes
                            len_d = 8'd2 + cap8(vjoin_len);
                        end
                    endcase
                end
                else if (take_rsp)
                begin
                    st_d      = S_HEAD;
                    body_d[0] = TYPE_RMT_RSP;  // [R13]
                    body_d[1] = rsp.frame_id;  // [R13]
                    for (int i = 0; i < 8; i++)
                    begin
                        body_d[2+i] = be8(rsp.src64, i);
                    end
                    body_d[10] = rsp.src16[15:8];
                    body_d[11] = rsp.src16[7:0];
                    body_d[12] = rsp.at_cmd[15:8];
                    body_d[13] = rsp.at_cmd[7:0];
                    body_d[14] = rsp.status;  // [R15]
                    for (int i = 0; i < 8; i++)
                    begin
                        body_d[15+i] = be8(rsp.data << (8*(8-cap8({4'h0, rsp.data_len}))), i);
                    end
                    len_d = rsp.param_set ? LEN_RSP_BASE : LEN_RSP_BASE + cap8({4'h0, rsp.data_len});  // [R14]
                end
            end
            S_HEAD:
            begin
                if (f_ready)
                begin
                    push_v = 1'b1;
                    case (idx_q[1:0])
                        2'd0:    push = mk_byte(1'b1, 1'b0, START_DELIM);  // [R1]
                        2'd1:    push = mk_byte(1'b0, 1'b0, 8'h00);  // [R2]
                        default: push = mk_byte(1'b0, 1'b0, len_q);  // [R2]
                    endcase
                    idx_d = idx_q + 8'd1;
                    if (idx_q == 8'd2)
                    begin
                        idx_d = 8'h00;
                        st_d  = S_BODY;
                    end
                end
            end
            S_BODY:
            begin
                if (f_ready)
                begin
                    push_v = 1'b1;
                    push   = mk_byte(1'b0, 1'b0, body_q[idx_q[4:0]]);
                    sum_d  = sum_q + body_q[idx_q[4:0]];  // [R17]
                    idx_d  = idx_q + 8'd1;
                    if (idx_q == len_q - 8'd1)
                    begin
                        st_d = S_SUM;
                    end
                end
            end
            S_SUM:
            begin
                if (f_ready)
                begin
                    push_v = 1'b1;
                    push   = mk_byte(1'b0, 1'b1, CSUM_BASE - sum_q);  // [R5] [R18]
                    st_d   = S_IDLE;  // [R17]
                end
            end
            default:
            begin
                st_d = S_IDLE;
            end
        endcase
        busy_d = (st_d != S_IDLE);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q      <= S_IDLE;
            len_q     <= 8'h00;
            idx_q     <= 8'h00;
            sum_q     <= 8'h00;
            busy_q    <= 1'b0;
            for (int i = 0; i < MAX_BODY; i++)
            begin
                body_q[i] <= 8'h00;
            end
        end
        else
        begin
            st_q      <= st_d;
            len_q     <= len_d;
            idx_q     <= idx_d;
            sum_q     <= sum_d;
            busy_q    <= busy_d;
            body_q    <= body_d;
        end
    end

    // ************************************************
    // request handshake
    // ************************************************
    // a refused request still pulses ready,
    // so a requester never waits forever
    always_comb
    begin
        ev_rdy_d  = take_ev | ev_drop;
        rsp_rdy_d = take_rsp | rsp_drop;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ev_rdy_q  <= 1'b0;
            rsp_rdy_q <= 1'b0;
        end
        else
        begin
            ev_rdy_q  <= ev_rdy_d;
            rsp_rdy_q <= rsp_rdy_d;
        end
    end

    // ************************************************
    // byte fifo toward host
    // ************************************************
    esf_fifo #(
        .WIDTH (10),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push_v),
        .in_ready  (f_ready),
        .in_data   (push),
        .out_valid (host_valid),
        .out_ready (host_ready),
        .out_data  (f_out)
    );

    // ************************************************
    // outputs
    // ************************************************
    // every output is a flop; no comb path to the host
    assign host_byte = f_out;
    assign ev_ready  = ev_rdy_q;
    assign rsp_ready = rsp_rdy_q;
    assign busy      = busy_q;
endmodule

/* File: tb/esf_chk_sva.sv */
// Purpose: port checker for esf_emitter
// Assumes: byte index counted on accepted host bytes
// Notes:   bind at file foot
`timescale 1ns/100ps
module esf_chk
    import esf_pkg::*;
(
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               ev_valid,
    input wire logic               ev_ready,
    input wire esf_pkg::esf_event_t ev,
    input wire logic               rsp_ready,
    input wire esf_pkg::esf_rsp_t  rsp,
    input wire logic               joining_controls_setting,
    input wire logic               extended_api_options_setting,
    input wire logic [7:0]         api_mode_setting,
    input wire logic               host_valid,
    input wire logic               host_ready,
    input wire esf_pkg::esf_byte_t host_byte,
    input wire logic               busy
);
    // ********
    // frame tracking
    // ********
    logic [7:0] idx_q;
    logic [7:0] sum_q;
    logic [7:0] len_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            idx_q <= 8'h00;
            sum_q <= 8'h00;
            len_q <= 8'h00;
        end
        else if (host_valid && host_ready)
        begin
            idx_q <= host_byte.eop ? 8'h00 : idx_q + 8'h01;
            sum_q <= host_byte.eop ? 8'h00 : (idx_q >= 8'h03 ? sum_q + host_byte.data : sum_q);
            if (idx_q == 8'h02) len_q <= host_byte.data;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_start_delim: assert property (host_valid && host_byte.sop |-> host_byte.data == 8'h7E && idx_q == 8'h00)
        else $error("frame start wrong");
    a_len_high: assert property (host_valid && idx_q == 8'h01 |-> host_byte.data == 8'h00)
        else $error("length high byte wrong");
    a_frame_type: assert property (host_valid && idx_q == 8'h03 |-> host_byte.data inside {8'h98, 8'h97})
        else $error("frame type wrong");
    a_checksum: assert property (host_valid && host_byte.eop |-> host_byte.data == 8'(8'hFF - sum_q))
        else $error("checksum wrong");
    a_length_count: assert property (host_valid && host_byte.eop |-> idx_q == len_q + 8'h03)
        else $error("length field wrong");
    a_byte_hold: assert property (host_valid && !host_ready |=> host_valid && $stable(host_byte))
        else $error("byte dropped while stalled");
    a_take_answer: assert property (ev_valid && !busy && !ev_ready && !rsp_ready |=> ev_ready ##1 !ev_ready)
        else $error("event not answered");
    a_plain_only: assert property (ev_ready && api_mode_setting != 8'h01 |-> !busy)
        else $error("frame in non plain mode");
    a_session_gate: assert property (ev_ready && !extended_api_options_setting && ev.kind != EV_VJOIN |-> !busy)
        else $error("session frame while disabled");
    a_vjoin_gate: assert property (ev_ready && !joining_controls_setting && ev.kind == EV_VJOIN |-> !busy)
        else $error("join frame while disabled");
    a_zero_id: assert property (rsp_ready && rsp.frame_id == 8'h00 |-> !busy)
        else $error("response for zero id");
    cover property (host_valid && host_byte.eop);
    cover property (rsp_ready && busy);
    cover property (host_valid && !host_ready [*4]);
endmodule
bind esf_emitter esf_chk u_chk (.clk(clk), .rst(rst), .ev_valid(ev_valid), .ev_ready(ev_ready), .ev(ev),
    .rsp_ready(rsp_ready), .rsp(rsp), .joining_controls_setting(joining_controls_setting),
    .extended_api_options_setting(extended_api_options_setting), .api_mode_setting(api_mode_setting),
    .host_valid(host_valid), .host_ready(host_ready), .host_byte(host_byte), .busy(busy));

/* File: tb/esf_host_model.sv */
// Purpose: host side reader of status frames
// Assumes: byte taken when valid and ready
// Notes:   keeps only the last good frame
`timescale 1ns/100ps
module esf_host_model
    import esf_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               host_valid,
    output logic                    host_ready,
    input  wire esf_pkg::esf_byte_t host_byte,
    input  wire logic               stall,
    input  wire logic               slow
);
    // ********
    // receive
    // ********
    logic [7:0] cur[$];
    logic [7:0] last[$];
    logic [7:0] s;
    logic       tog;
    int         nfr = 0;
    int         nbad = 0;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            host_ready <= 1'b0;
            tog <= 1'b0;
        end
        else
        begin
            if (host_valid && host_ready)
            begin
                if (host_byte.sop) cur = {};
                cur.push_back(host_byte.data);
                if (host_byte.eop)
                begin
                    s = 8'h00;
                    for (int i = 3; i < cur.size(); i++) s += cur[i];
                    // bad sum: frame thrown away, as a real host would
                    if (s == 8'hFF) last = cur;
                    if (s == 8'hFF) nfr++;
                    else nbad++;
                end
            end
            tog <= !tog;
            host_ready <= !stall && !(slow && tog);
        end
    end
endmodule

/* File: tb/esf_emitter_bench.sv */
// Purpose: self-checking bench for esf_emitter
// Assumes: host model answers on the link
// Notes:   expected frames rebuilt from body bytes
`timescale 1ns/100ps
module esf_emitter_bench;
    import esf_pkg::*;
    logic       clk, rst, ev_valid, ev_ready, rsp_valid, rsp_ready, busy;
    logic       jc, xo, host_valid, host_ready, stall, slow;
    logic [7:0] api, vjoin_len;
    logic [63:0] vjoin_data;
    esf_event_t ev;
    esf_rsp_t   rsp;
    esf_byte_t  host_byte;
    logic [7:0] body[$];
    int         fails = 0, total_checks = 0, n0 = 0;
    esf_emitter #(.FDEPTH(16)) DUT (.clk(clk), .rst(rst), .ev_valid(ev_valid), .ev_ready(ev_ready), .ev(ev),
        .vjoin_len(vjoin_len), .vjoin_data(vjoin_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp(rsp), .joining_controls_setting(jc), .extended_api_options_setting(xo), .api_mode_setting(api),
        .host_valid(host_valid), .host_ready(host_ready), .host_byte(host_byte), .busy(busy));
    esf_host_model host (.clk(clk), .rst(rst), .host_valid(host_valid), .host_ready(host_ready),
        .host_byte(host_byte), .stall(stall), .slow(slow));
    // ********
    // helpers
    // ********
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic add(input logic [63:0] a, input int nb);
        for (int i = nb - 1; i >= 0; i--) body.push_back(a[i*8+:8]);
    endtask
    task automatic drain();
        for (int i = 0; i < 400 && (busy !== 1'b0 || host_valid !== 1'b0); i++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic send(input bit is_rsp, input bit wait_end);
        @(posedge clk);
        #1;
        ev_valid = !is_rsp;
        rsp_valid = is_rsp;
        for (int i = 0; i < 20 && ev_ready !== 1'b1 && rsp_ready !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        cmp("ready", 1, is_rsp ? rsp_ready : ev_ready);
        ev_valid = 0;
        rsp_valid = 0;
        if (wait_end) drain();
    endtask
    task automatic check(input string n, input bit want);
        logic [7:0] f[$];
        logic [7:0] s;
        s = 8'h00;
        foreach (body[i]) s += body[i];
        f = {8'h7E, 8'h00, 8'(body.size()), body, 8'(8'hFF - s)};
        cmp(n, n0 + int'(want), host.nfr);
        if (want) cmp(n, f.size(), host.last.size());
        if (want) foreach (f[i]) cmp(n, f[i], host.last[i]);
        n0 = host.nfr;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_session();
        ev = '{EV_SESS_UP, 64'h0013A20012345678, 8'h00, 8'h00, 16'h4650};
        body = {8'h98, 8'h3B, 8'h00, 8'h13, 8'hA2, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h46, 8'h50};
        send(0, 1);
        check("sess_up", 1);
        cmp("sess_up sum", 8'hCD, host.last[16]);
        for (int r = 0; r < 6; r++)
        begin
            slow = r[0];
            ev = '{r < 5 ? EV_SESS_END : EV_AUTH_FAIL, 64'h1122334455667788, 8'(r), 8'h00, 16'h0000};
            body = {8'h98, r < 5 ? 8'h3C : 8'h3D};
            add(ev.addr, 8);
            body.push_back(8'(r));
            send(0, 1);
            check("sess_end", 1);
        end
        slow = 0;
        $display("test session done");
    endtask
    task automatic t_gates();
        xo = 0;
        send(0, 1);
        check("ext off", 0);
        xo = 1;
        jc = 0;
        ev = '{EV_VJOIN, 64'h0, 8'h21, 8'h00, 16'h0};
        send(0, 1);
        check("join off", 0);
        jc = 1;
        body = {8'h98, 8'h21, 8'hA5, 8'hC3};
        send(0, 1);
        check("join on", 1);
        for (int m = 0; m < 3; m += 2)
        begin
            api = 8'(m);
            send(0, 1);
            check("api mode", 0);
        end
        api = 8'h01;
        $display("test gates done");
    endtask
    task automatic t_response();
        rsp = '{8'h27, 64'h0013A20012345678, 16'h127E, 16'h4E49, 8'h00, 1'b1, 4'h0, 64'h0};
        body = {8'h97, 8'h27};
        add(rsp.src64, 8);
        add(64'h127E4E4900, 5);
        send(1, 1);
        check("rsp set", 1);
        cmp("rsp set sum", 8'h51, host.last[18]);
        rsp = '{8'h27, 64'h0013A20012345678, 16'hFFFE, 16'h5450, 8'h00, 1'b0, 4'h2, 64'h002F};
        body = {8'h97, 8'h27};
        add(rsp.src64, 8);
        add(64'hFFFE54500000, 6);
        body.push_back(8'h2F);
        send(1, 1);
        check("rsp query", 1);
        cmp("rsp query sum", 8'hA8, host.last[20]);
        for (int s = 0; s < 5; s++)
        begin
            rsp = '{8'h27, 64'h0013A20012345678, 16'hFFFE, 16'h5450, 8'(s), 1'b1, 4'h0, 64'h0};
            body = body[0:13];
            body.push_back(8'(s));
            send(1, 1);
            check("rsp status", 1);
        end
        rsp.frame_id = 8'h00;
        send(1, 1);
        check("rsp zero id", 0);
        $display("test response done");
    endtask
    task automatic t_stall();
        logic seen;
        stall = 1;
        rsp = '{8'h31, 64'h0102030405060708, 16'h0A0B, 16'h4142, 8'h03, 1'b0, 4'h8, 64'hF0E1D2C3B4A59687};
        body = {8'h97, 8'h31};
        add(rsp.src64, 8);
        add(64'h0A0B414203, 5);
        add(rsp.data, 8);
        send(1, 0);
        repeat (60) @(posedge clk);
        #1;
        cmp("full busy", 1, busy);
        cmp("full valid", 1, host_valid);
        ev_valid = 1;
        seen = 0;
        repeat (4)
        begin
            @(posedge clk);
            #1;
            seen |= ev_ready;
        end
        ev_valid = 0;
        cmp("busy ignores", 0, seen);
        stall = 0;
        drain();
        check("stall frame", 1);
        $display("test stall done");
    endtask
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        // far above the few hundred cycles the tests need
        #500000;
        fails++;
        print_verdict();
    end
    initial
    begin
        {rst, ev_valid, rsp_valid, stall, slow} = 5'b10000;
        {jc, xo} = 2'b11;
        api = API_PLAIN;
        vjoin_len = 8'h02;
        {ev, rsp, vjoin_data} = '0;
        vjoin_data = 64'hA5C3000000000000;
        repeat (4) @(posedge clk);
        #1;
        rst = 0;
        cmp("reset busy", 0, busy);
        cmp("reset valid", 0, host_valid);
        t_session();
        t_gates();
        t_response();
        t_stall();
        print_verdict();
    end
endmodule
